// ==== common/ucf_pkg.sv ====
// Shared constants, types and helpers for the UART command framer.
// Assumes both ends run on one clock and exchange whole bytes.
package ucf_pkg;

  // Frame delimiters and packet types
  localparam logic [7:0] START_DELIM = 8'h02;
  localparam logic [7:0] END_DELIM = 8'h03;
  localparam logic [7:0] TYPE_REQUEST = 8'h52;
  localparam logic [7:0] TYPE_CONFIRM = 8'h43;
  localparam logic [7:0] TYPE_INDICATION = 8'h69;
  localparam logic [7:0] TYPE_REPLY = 8'h72;
  localparam logic [15:0] MAX_PAYLOAD = 16'h014d;
  // Header is start, type, opcode, length low, length high, check byte
  localparam logic [2:0] HDR_LAST = 3'h5;

  // Opcodes of the transport commands; values are arbitrary
  localparam logic [7:0] DEF_OP_DISABLE_TL = 8'h01;
  localparam logic [7:0] DEF_OP_TL_ENABLED = 8'h02;
  localparam logic [7:0] DEF_OP_TRANSPARENT = 8'h03;

  localparam int TX_FIFO_DEPTH = 4;
  localparam int BYTE_W = 8;

  // Power modes: uart off/on in bit 0, radio level above it
  localparam logic [2:0] POWER_MODE_ALL_OFF = 3'h0;
  localparam logic [2:0] POWER_MODE_SLOW_REF = 3'h2;
  localparam logic [2:0] POWER_MODE_UART_AND_LINK_ON = 3'h5;
  // Slow reference usable in the scanning, uart-off mode
  localparam int SLOW_REF_HZ = 32768;

  typedef enum logic [1:0] {RADIO_OFF, RADIO_SCAN, RADIO_LINK} ucf_radio_t;
  typedef enum logic [2:0] {RX_SYNC, RX_TYPE, RX_OP, RX_LLO, RX_LHI, RX_BCC, RX_PAY, RX_END} ucf_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY, TX_END} ucf_tx_st_t;

  function automatic logic [7:0] ucf_bcc(input logic [7:0] typ, input logic [7:0] op, input logic [15:0] len);
    logic [9:0] sum;
    sum = {2'h0, typ} + {2'h0, op} + {2'h0, len[7:0]} + {2'h0, len[15:8]};
    return sum[7:0];
  endfunction

  function automatic logic [7:0] ucf_hdr_byte(input logic [2:0] idx, input logic [7:0] typ,
                                              input logic [7:0] op, input logic [15:0] len);
    case (idx)
      3'h0: return START_DELIM;
      3'h1: return typ;
      3'h2: return op;
      3'h3: return len[7:0];
      3'h4: return len[15:8];
      default: return ucf_bcc(typ, op, len);
    endcase
  endfunction

endpackage

// ==== common/ucf_link_if.sv ====
// Byte link plus null-modem RTS/CTS between device and host ends.
// Both ends share one clock; each byte is a one-cycle valid strobe.
`timescale 1ns/1ps
interface ucf_link_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic [7:0] d2h_data;
  logic d2h_valid;
  // Active low; each party's RTS is the other's CTS
  logic host_rts_n;
  logic dev_rts_n;

  modport device (input h2d_data, input h2d_valid, input host_rts_n,
                  output d2h_data, output d2h_valid, output dev_rts_n);
  modport host (output h2d_data, output h2d_valid, output host_rts_n,
                input d2h_data, input d2h_valid, input dev_rts_n);
endinterface

// ==== logic/ucf_device_end.sv ====
// Device end of the UART command framer: packet receive and transmit,
// transport disable and hardware wake-up, power mode status.
// Assumes the host end on the same clock through ucf_link_if.
`timescale 1ns/1ps

module ucf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire empty = (wr_ff == rd_ff);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_ff[rd_ff[AW-1:0]];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) mem_ff[wr_ff[AW-1:0]] <= i_in_data;
  end
endmodule

module ucf_device_end #(
  parameter logic [7:0] OP_DISABLE_TL = ucf_pkg::DEF_OP_DISABLE_TL,
  parameter logic [7:0] OP_TL_ENABLED = ucf_pkg::DEF_OP_TL_ENABLED,
  parameter logic [7:0] OP_TRANSPARENT = ucf_pkg::DEF_OP_TRANSPARENT,
  parameter int FIFO_DEPTH = ucf_pkg::TX_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  // Link to host
  ucf_link_if.device link,
  // Radio activity
  input wire ucf_pkg::ucf_radio_t i_radio,
  // Received commands
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_type,
  output logic [7:0] o_cmd_opcode,
  output logic [15:0] o_cmd_len,
  output logic o_cmd_err,
  output logic o_pl_valid,
  output logic [7:0] o_pl_data,
  // Packets to send
  input wire logic i_tx_req,
  input wire logic [7:0] i_tx_type,
  input wire logic [7:0] i_tx_opcode,
  input wire logic [15:0] i_tx_len,
  output logic o_tx_ack,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Status
  output logic o_uart_on,
  output logic o_transparent,
  output logic [2:0] o_power_mode,
  output logic o_slow_ref_ok
);
  import ucf_pkg::*;

  typedef enum logic [2:0] {TL_ON, TL_DRAIN, TL_OFF_CFM, TL_OFF, TL_DEV_WAKE, TL_WAKE_CFM} ucf_tl_st_t;

  ucf_tl_st_t tl_ff, nxt_tl;
  ucf_rx_st_t rx_ff;
  ucf_tx_st_t tx_ff;
  logic cts_s1_ff, cts_s2_ff, cts_prev_ff;
  logic [7:0] rx_type_ff, rx_op_ff;
  logic [15:0] rx_len_ff, rx_cnt_ff;
  logic req_dis_ff, req_trans_ff;
  logic cmd_valid_ff, cmd_err_ff, pl_valid_ff;
  logic [7:0] pl_data_ff;
  logic cfm_pend_ff;
  logic [7:0] cfm_op_ff;
  logic [7:0] tx_type_ff, tx_op_ff;
  logic [15:0] tx_len_ff, tx_cnt_ff;
  logic tx_int_ff, tx_ack_ff, d2h_valid_ff, dev_rts_n_ff, trans_ff;
  logic [7:0] d2h_data_ff;
  logic [2:0] pm_ff;
  logic fifo_valid;
  logic [7:0] fifo_data;

  // CTS from the host pin: two flops, then edge detect on the second
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // CTS idles low while the transport is on; no false edge after reset
      cts_s1_ff <= 1'b0;
      cts_s2_ff <= 1'b0;
      cts_prev_ff <= 1'b0;
    end else begin
      cts_s1_ff <= link.host_rts_n;
      cts_s2_ff <= cts_s1_ff;
      cts_prev_ff <= cts_s2_ff;
    end
  end
  wire cts_fall = cts_prev_ff && !cts_s2_ff;

  wire [7:0] rx_b = link.h2d_data;
  // Bytes count only with the transport fully on; nothing is taken while waking
  wire rx_on = link.h2d_valid && (tl_ff == TL_ON);
  wire rx_frame = rx_on && !trans_ff;
  wire rx_raw = rx_on && trans_ff;
  wire rx_bcc_bad = (rx_b != ucf_bcc(rx_type_ff, rx_op_ff, rx_len_ff)) || (rx_len_ff > MAX_PAYLOAD);
  wire rx_is_req = (rx_type_ff == TYPE_REQUEST);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_ff <= RX_SYNC;
      rx_type_ff <= 8'h00;
      rx_op_ff <= 8'h00;
      rx_len_ff <= 16'h0000;
      rx_cnt_ff <= 16'h0000;
      cmd_valid_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
      pl_valid_ff <= 1'b0;
      pl_data_ff <= 8'h00;
      req_dis_ff <= 1'b0;
      req_trans_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
      pl_valid_ff <= rx_raw || (rx_frame && rx_ff == RX_PAY);
      req_dis_ff <= 1'b0;
      req_trans_ff <= 1'b0;
      if (rx_raw) pl_data_ff <= rx_b;
      if (rx_frame) begin
        case (rx_ff)
          RX_SYNC: if (rx_b == START_DELIM) rx_ff <= RX_TYPE;
          RX_TYPE: begin
            rx_type_ff <= rx_b;
            rx_ff <= RX_OP;
          end
          RX_OP: begin
            rx_op_ff <= rx_b;
            rx_ff <= RX_LLO;
          end
          RX_LLO: begin
            rx_len_ff[7:0] <= rx_b;
            rx_ff <= RX_LHI;
          end
          RX_LHI: begin
            rx_len_ff[15:8] <= rx_b;
            rx_ff <= RX_BCC;
          end
          RX_BCC: begin
            rx_cnt_ff <= 16'h0000;
            if (rx_bcc_bad) begin
              cmd_err_ff <= 1'b1;
              rx_ff <= RX_SYNC;
            end else begin
              rx_ff <= (rx_len_ff == 16'h0000) ? RX_END : RX_PAY;
            end
          end
          RX_PAY: begin
            pl_data_ff <= rx_b;
            rx_cnt_ff <= rx_cnt_ff + 16'h0001;
            if (rx_cnt_ff == rx_len_ff - 16'h0001) rx_ff <= RX_END;
          end
          RX_END: begin
            rx_ff <= RX_SYNC;
            if (rx_b != END_DELIM) cmd_err_ff <= 1'b1;
            else if (rx_is_req && rx_op_ff == OP_DISABLE_TL) req_dis_ff <= 1'b1;
            else if (rx_is_req && rx_op_ff == OP_TRANSPARENT) req_trans_ff <= 1'b1;
            else cmd_valid_ff <= 1'b1;
          end
          default: rx_ff <= RX_SYNC;
        endcase
      end
    end
  end

  // Transport state and internal confirms
  wire tx_idle = (tx_ff == TX_IDLE);
  wire int_done = (tx_ff == TX_END) && tx_int_ff;
  wire int_sent = tx_idle && tx_int_ff && !cfm_pend_ff;
  wire drained = tx_idle && !fifo_valid && !i_tx_req && !cfm_pend_ff;
  wire pending_evt = i_tx_req || fifo_valid;
  wire tl_on = (tl_ff == TL_ON);

  always_comb begin
    nxt_tl = tl_ff;
    case (tl_ff)
      TL_ON: if (req_dis_ff) nxt_tl = TL_DRAIN;
      TL_DRAIN: if (drained) nxt_tl = TL_OFF_CFM;
      // End byte must be out before RTS rises
      TL_OFF_CFM: if (int_sent && tx_op_ff == OP_DISABLE_TL) nxt_tl = TL_OFF;
      TL_OFF: begin
        if (cts_fall) nxt_tl = TL_WAKE_CFM;
        else if (pending_evt) nxt_tl = TL_DEV_WAKE;
      end
      // Edge, not level: the synchroniser may still hold the old low CTS
      TL_DEV_WAKE: if (cts_fall) nxt_tl = TL_WAKE_CFM;
      TL_WAKE_CFM: if (int_done && tx_op_ff == OP_TL_ENABLED) nxt_tl = TL_ON;
      default: nxt_tl = TL_ON;
    endcase
  end

  wire cfm_set = req_trans_ff || (nxt_tl != tl_ff && (nxt_tl == TL_OFF_CFM || nxt_tl == TL_WAKE_CFM));
  wire [7:0] cfm_op = req_trans_ff ? OP_TRANSPARENT : (nxt_tl == TL_OFF_CFM) ? OP_DISABLE_TL : OP_TL_ENABLED;
  wire cfm_take = tx_idle && cfm_pend_ff;
  wire uart_on = (nxt_tl != TL_OFF) && (nxt_tl != TL_DEV_WAKE);
  wire [2:0] radio_lvl = {1'b0, i_radio};
  wire [2:0] pm = {radio_lvl[1:0], uart_on};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tl_ff <= TL_ON;
      dev_rts_n_ff <= 1'b0;
      cfm_pend_ff <= 1'b0;
      cfm_op_ff <= 8'h00;
      trans_ff <= 1'b0;
      pm_ff <= POWER_MODE_ALL_OFF;
    end else begin
      tl_ff <= nxt_tl;
      // RTS idle high only while the transport is off
      dev_rts_n_ff <= (nxt_tl == TL_OFF);
      if (cfm_take) cfm_pend_ff <= 1'b0;
      if (cfm_set) begin
        cfm_pend_ff <= 1'b1;
        cfm_op_ff <= cfm_op;
      end
      if (int_done && tx_op_ff == OP_TRANSPARENT) trans_ff <= 1'b1;
      pm_ff <= pm;
    end
  end

  // Transmit framer
  wire user_ok = (tl_on || tl_ff == TL_DRAIN) && !trans_ff;
  wire raw_tx = tx_idle && !cfm_pend_ff && tl_on && trans_ff;
  wire fifo_pop = fifo_valid && ((tx_ff == TX_PAY) || raw_tx);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_ff <= TX_IDLE;
      tx_type_ff <= 8'h00;
      tx_op_ff <= 8'h00;
      tx_len_ff <= 16'h0000;
      tx_cnt_ff <= 16'h0000;
      tx_int_ff <= 1'b0;
      tx_ack_ff <= 1'b0;
      d2h_valid_ff <= 1'b0;
      d2h_data_ff <= 8'h00;
    end else begin
      tx_ack_ff <= 1'b0;
      d2h_valid_ff <= 1'b0;
      case (tx_ff)
        TX_IDLE: begin
          tx_cnt_ff <= 16'h0000;
          if (cfm_pend_ff) begin
            tx_type_ff <= TYPE_CONFIRM;
            tx_op_ff <= cfm_op_ff;
            tx_len_ff <= 16'h0000;
            tx_int_ff <= 1'b1;
            tx_ff <= TX_HDR;
          end else if (user_ok && i_tx_req) begin
            tx_type_ff <= i_tx_type;
            tx_op_ff <= i_tx_opcode;
            tx_len_ff <= i_tx_len;
            tx_int_ff <= 1'b0;
            tx_ack_ff <= 1'b1;
            tx_ff <= TX_HDR;
          end else if (raw_tx && fifo_valid) begin
            d2h_valid_ff <= 1'b1;
            d2h_data_ff <= fifo_data;
          end
        end
        TX_HDR: begin
          d2h_valid_ff <= 1'b1;
          d2h_data_ff <= ucf_hdr_byte(tx_cnt_ff[2:0], tx_type_ff, tx_op_ff, tx_len_ff);
          tx_cnt_ff <= tx_cnt_ff + 16'h0001;
          if (tx_cnt_ff[2:0] == HDR_LAST) begin
            tx_cnt_ff <= 16'h0000;
            tx_ff <= (tx_len_ff == 16'h0000) ? TX_END : TX_PAY;
          end
        end
        TX_PAY: if (fifo_valid) begin
          d2h_valid_ff <= 1'b1;
          d2h_data_ff <= fifo_data;
          tx_cnt_ff <= tx_cnt_ff + 16'h0001;
          if (tx_cnt_ff == tx_len_ff - 16'h0001) tx_ff <= TX_END;
        end
        TX_END: begin
          d2h_valid_ff <= 1'b1;
          d2h_data_ff <= END_DELIM;
          tx_ff <= TX_IDLE;
        end
        default: tx_ff <= TX_IDLE;
      endcase
    end
  end

  ucf_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_data),
    .o_in_ready(o_tx_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(fifo_pop)
  );

  assign link.d2h_data = d2h_data_ff;
  assign link.d2h_valid = d2h_valid_ff;
  assign link.dev_rts_n = dev_rts_n_ff;
  assign o_cmd_valid = cmd_valid_ff;
  assign o_cmd_type = rx_type_ff;
  assign o_cmd_opcode = rx_op_ff;
  assign o_cmd_len = rx_len_ff;
  assign o_cmd_err = cmd_err_ff;
  assign o_pl_valid = pl_valid_ff;
  assign o_pl_data = pl_data_ff;
  assign o_tx_ack = tx_ack_ff;
  assign o_uart_on = (tl_ff != TL_OFF) && (tl_ff != TL_DEV_WAKE);
  assign o_transparent = trans_ff;
  assign o_power_mode = pm_ff;
  assign o_slow_ref_ok = (pm_ff == POWER_MODE_SLOW_REF);
endmodule

// ==== logic/ucf_host_end.sv ====
// Host end of the UART command framer: sends packets, parses replies,
// tracks transport state and runs the RTS/CTS wake-up handshake.
// Assumes the device end on the same clock through ucf_link_if.
`timescale 1ns/1ps
module ucf_host_end #(
  parameter logic [7:0] OP_DISABLE_TL = ucf_pkg::DEF_OP_DISABLE_TL,
  parameter logic [7:0] OP_TL_ENABLED = ucf_pkg::DEF_OP_TL_ENABLED
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  // Link to device
  ucf_link_if.host link,
  // Packets to send
  input wire logic i_send,
  input wire logic [7:0] i_type,
  input wire logic [7:0] i_opcode,
  input wire logic [15:0] i_len,
  output logic o_send_ack,
  input wire logic [7:0] i_pl_data,
  output logic o_pl_take,
  // Received packets
  output logic o_evt_valid,
  output logic [7:0] o_evt_type,
  output logic [7:0] o_evt_opcode,
  output logic [15:0] o_evt_len,
  output logic o_evt_err,
  output logic o_pl_valid,
  output logic [7:0] o_pl_data,
  // Status
  output logic o_link_on
);
  import ucf_pkg::*;

  typedef enum logic [1:0] {H_ON, H_OFF, H_WAKE} ucf_host_st_t;

  ucf_host_st_t hs_ff;
  ucf_rx_st_t rx_ff;
  ucf_tx_st_t tx_ff;
  logic cts_s1_ff, cts_s2_ff, cts_prev_ff;
  logic [7:0] rx_type_ff, rx_op_ff, pl_data_ff;
  logic [15:0] rx_len_ff, rx_cnt_ff;
  logic evt_valid_ff, evt_err_ff, pl_valid_ff;
  logic [7:0] tx_type_ff, tx_op_ff, h2d_data_ff;
  logic [15:0] tx_len_ff, tx_cnt_ff;
  logic pace_ff, ack_ff, take_ff, h2d_valid_ff, rts_n_ff;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // CTS idles low while the transport is on
      cts_s1_ff <= 1'b0;
      cts_s2_ff <= 1'b0;
      cts_prev_ff <= 1'b0;
    end else begin
      cts_s1_ff <= link.dev_rts_n;
      cts_s2_ff <= cts_s1_ff;
      cts_prev_ff <= cts_s2_ff;
    end
  end

  // Receive parser
  wire [7:0] rx_b = link.d2h_data;
  wire rx_bad = (rx_b != ucf_bcc(rx_type_ff, rx_op_ff, rx_len_ff)) || (rx_len_ff > MAX_PAYLOAD);
  wire rx_good_end = link.d2h_valid && rx_ff == RX_END && rx_b == END_DELIM;
  wire is_cfm = rx_good_end && rx_type_ff == TYPE_CONFIRM;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_ff <= RX_SYNC;
      rx_type_ff <= 8'h00;
      rx_op_ff <= 8'h00;
      rx_len_ff <= 16'h0000;
      rx_cnt_ff <= 16'h0000;
      evt_valid_ff <= 1'b0;
      evt_err_ff <= 1'b0;
      pl_valid_ff <= 1'b0;
      pl_data_ff <= 8'h00;
    end else begin
      evt_valid_ff <= rx_good_end;
      evt_err_ff <= 1'b0;
      pl_valid_ff <= link.d2h_valid && rx_ff == RX_PAY;
      if (link.d2h_valid) begin
        case (rx_ff)
          RX_SYNC: if (rx_b == START_DELIM) rx_ff <= RX_TYPE;
          RX_TYPE: begin
            rx_type_ff <= rx_b;
            rx_ff <= RX_OP;
          end
          RX_OP: begin
            rx_op_ff <= rx_b;
            rx_ff <= RX_LLO;
          end
          RX_LLO: begin
            rx_len_ff[7:0] <= rx_b;
            rx_ff <= RX_LHI;
          end
          RX_LHI: begin
            rx_len_ff[15:8] <= rx_b;
            rx_ff <= RX_BCC;
          end
          RX_BCC: begin
            rx_cnt_ff <= 16'h0000;
            evt_err_ff <= rx_bad;
            if (rx_bad) rx_ff <= RX_SYNC;
            else rx_ff <= (rx_len_ff == 16'h0000) ? RX_END : RX_PAY;
          end
          RX_PAY: begin
            pl_data_ff <= rx_b;
            rx_cnt_ff <= rx_cnt_ff + 16'h0001;
            if (rx_cnt_ff == rx_len_ff - 16'h0001) rx_ff <= RX_END;
          end
          RX_END: begin
            evt_err_ff <= (rx_b != END_DELIM);
            rx_ff <= RX_SYNC;
          end
          default: rx_ff <= RX_SYNC;
        endcase
      end
    end
  end

  // Transport state and wake-up handshake
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hs_ff <= H_ON;
      rts_n_ff <= 1'b0;
    end else begin
      case (hs_ff)
        H_ON: if (is_cfm && rx_op_ff == OP_DISABLE_TL) begin
          hs_ff <= H_OFF;
          rts_n_ff <= 1'b1;
        end
        H_OFF: if ((cts_prev_ff && !cts_s2_ff) || i_send) begin
          hs_ff <= H_WAKE;
          rts_n_ff <= 1'b0;
        end
        H_WAKE: if (is_cfm && rx_op_ff == OP_TL_ENABLED) hs_ff <= H_ON;
        default: hs_ff <= H_ON;
      endcase
    end
  end

  // Transmit framer, one byte every other clock
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_ff <= TX_IDLE;
      tx_type_ff <= 8'h00;
      tx_op_ff <= 8'h00;
      tx_len_ff <= 16'h0000;
      tx_cnt_ff <= 16'h0000;
      pace_ff <= 1'b0;
      ack_ff <= 1'b0;
      take_ff <= 1'b0;
      h2d_valid_ff <= 1'b0;
      h2d_data_ff <= 8'h00;
    end else begin
      ack_ff <= 1'b0;
      take_ff <= 1'b0;
      h2d_valid_ff <= 1'b0;
      pace_ff <= !pace_ff;
      case (tx_ff)
        TX_IDLE: begin
          tx_cnt_ff <= 16'h0000;
          if (i_send && hs_ff == H_ON) begin
            tx_type_ff <= i_type;
            tx_op_ff <= i_opcode;
            tx_len_ff <= i_len;
            ack_ff <= 1'b1;
            pace_ff <= 1'b1;
            tx_ff <= TX_HDR;
          end
        end
        TX_HDR: if (pace_ff) begin
          h2d_valid_ff <= 1'b1;
          h2d_data_ff <= ucf_hdr_byte(tx_cnt_ff[2:0], tx_type_ff, tx_op_ff, tx_len_ff);
          tx_cnt_ff <= tx_cnt_ff + 16'h0001;
          if (tx_cnt_ff[2:0] == HDR_LAST) begin
            tx_cnt_ff <= 16'h0000;
            tx_ff <= (tx_len_ff == 16'h0000) ? TX_END : TX_PAY;
          end
        end
        TX_PAY: if (pace_ff) begin
          h2d_valid_ff <= 1'b1;
          h2d_data_ff <= i_pl_data;
          take_ff <= 1'b1;
          tx_cnt_ff <= tx_cnt_ff + 16'h0001;
          if (tx_cnt_ff == tx_len_ff - 16'h0001) tx_ff <= TX_END;
        end
        TX_END: if (pace_ff) begin
          h2d_valid_ff <= 1'b1;
          h2d_data_ff <= END_DELIM;
          tx_ff <= TX_IDLE;
        end
        default: tx_ff <= TX_IDLE;
      endcase
    end
  end

  assign link.h2d_data = h2d_data_ff;
  assign link.h2d_valid = h2d_valid_ff;
  assign link.host_rts_n = rts_n_ff;
  assign o_send_ack = ack_ff;
  assign o_pl_take = take_ff;
  assign o_evt_valid = evt_valid_ff;
  assign o_evt_type = rx_type_ff;
  assign o_evt_opcode = rx_op_ff;
  assign o_evt_len = rx_len_ff;
  assign o_evt_err = evt_err_ff;
  assign o_pl_valid = pl_valid_ff;
  assign o_pl_data = pl_data_ff;
  assign o_link_on = (hs_ff == H_ON);
endmodule

// ==== testbench/ucf_properties.sv ====
// Checker on the device-to-host byte stream and the RTS wires.
// Assumes the signals of the one link joining both ends.
`timescale 1ns/1ps
module ucf_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Link signals
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic host_rts_n,
  input wire logic dev_rts_n
);
  import ucf_pkg::*;
  logic [2:0] c_ff;
  logic [7:0] s_ff;
  logic [7:0] lo_ff;
  logic [15:0] rem_ff;
  logic pl_ff;
  logic w_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Frame tracker: header position, sum, payload left
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {c_ff, s_ff, lo_ff, rem_ff, pl_ff, w_ff} <= '0;
    end else begin
      w_ff <= $fell(dev_rts_n) | (w_ff & !d2h_valid);
      if (d2h_valid && c_ff != 3'h0) begin
        c_ff <= (c_ff == HDR_LAST) ? 3'h0 : c_ff + 3'h1;
        s_ff <= s_ff + d2h_data;
        pl_ff <= (c_ff == HDR_LAST);
        if (c_ff == 3'h3) lo_ff <= d2h_data;
        if (c_ff == 3'h4) rem_ff <= {d2h_data, lo_ff};
      end else if (d2h_valid && pl_ff) begin
        pl_ff <= (rem_ff != 16'h0);
        rem_ff <= rem_ff - 16'h1;
      end else if (d2h_valid) begin
        c_ff <= {2'h0, d2h_data == START_DELIM};
        s_ff <= 8'h0;
      end
    end
  end
  rts_reset_a: assert property ($rose(i_nrst) |-> !dev_rts_n) else $error("rts off at reset");
  off_after_end_a: assert property ($rose(dev_rts_n) |-> $past(d2h_valid && d2h_data == END_DELIM))
    else $error("rts off not after end byte");
  off_silent_a: assert property (dev_rts_n |-> !d2h_valid) else $error("byte sent while off");
  wake_ack_a: assert property ($fell(host_rts_n) && dev_rts_n |-> ##[1:8] !dev_rts_n)
    else $error("no wake ack");
  wake_first_a: assert property (w_ff && d2h_valid |-> d2h_data == START_DELIM ##1
    d2h_data == TYPE_CONFIRM ##1 d2h_data == DEF_OP_TL_ENABLED) else $error("wake confirm wrong");
  wake_bound_a: assert property ($fell(dev_rts_n) |-> ##[1:60] d2h_valid) else $error("no wake confirm");
  hdr_contig_a: assert property (c_ff != 3'h0 |-> d2h_valid) else $error("header gap");
  frame_start_a: assert property (d2h_valid && c_ff == 3'h0 && !pl_ff |-> d2h_data == START_DELIM)
    else $error("bad start byte");
  check_byte_a: assert property (d2h_valid && c_ff == HDR_LAST |-> d2h_data == s_ff) else $error("bad check");
  frame_end_a: assert property (d2h_valid && pl_ff && rem_ff == 16'h0 |-> d2h_data == END_DELIM)
    else $error("bad end byte");
endmodule

// ==== testbench/uart_command_framer_wakeup_tb_top.sv ====
// Bench: host and device ends joined by one link, checked end to end.
// Assumes ucf_pkg and the link interface compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
`define WT(c) begin for (k = 0; k < 2000 && !(c); k++) @(negedge i_clk); if (!(c)) begin n_mismatch++; summarize(); end end
module uart_command_framer_wakeup_tb_top;
  import ucf_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, tx_req = 1'b0, tx_valid = 1'b0, send = 1'b0;
  logic [7:0] tx_type = 8'h0, tx_op = 8'h0, tx_data = 8'h0, h_type = 8'h0, h_op = 8'h0, dpl_l, hpl_l;
  logic [15:0] tx_len = 16'h0, h_len = 16'h0, pidx = 16'h0;
  ucf_radio_t radio = RADIO_OFF;
  logic cmd_v, cmd_e, dpl_v, tx_ready, uart_on, evt_v, evt_e, hpl_v, pl_take, tx_ack, send_ack, slow, trans;
  logic [7:0] cmd_t, cmd_o, dpl_d, evt_t, evt_o, hpl_d;
  logic [15:0] cmd_ln, evt_ln;
  logic [2:0] pmode;
  logic [31:0] cmd_l, evq[$];
  int n_mismatch = 0, n_checks = 0, k, cmd_n = 0, err_n = 0, dpl_n = 0, dpl_b = 0;
  ucf_link_if link();
  ucf_device_end i_ucf_device_end (.i_clk(i_clk), .i_nrst(i_nrst), .link(link), .i_radio(radio),
    .o_cmd_valid(cmd_v), .o_cmd_type(cmd_t), .o_cmd_opcode(cmd_o), .o_cmd_len(cmd_ln), .o_cmd_err(cmd_e),
    .o_pl_valid(dpl_v), .o_pl_data(dpl_d), .i_tx_req(tx_req), .i_tx_type(tx_type), .i_tx_opcode(tx_op),
    .i_tx_len(tx_len), .o_tx_ack(tx_ack), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
    .o_uart_on(uart_on), .o_transparent(trans), .o_power_mode(pmode), .o_slow_ref_ok(slow));
  ucf_host_end i_ucf_host_end (.i_clk(i_clk), .i_nrst(i_nrst), .link(link), .i_send(send), .i_type(h_type),
    .i_opcode(h_op), .i_len(h_len), .o_send_ack(send_ack), .i_pl_data({4'h4, pidx[3:0]}), .o_pl_take(pl_take),
    .o_evt_valid(evt_v), .o_evt_type(evt_t), .o_evt_opcode(evt_o), .o_evt_len(evt_ln), .o_evt_err(evt_e),
    .o_pl_valid(hpl_v), .o_pl_data(hpl_d), .o_link_on());
  ucf_properties i_ucf_properties (.i_clk(i_clk), .i_nrst(i_nrst), .h2d_data(link.h2d_data),
    .h2d_valid(link.h2d_valid), .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid),
    .host_rts_n(link.host_rts_n), .dev_rts_n(link.dev_rts_n));
  always #4 i_clk = ~i_clk;
  always @(negedge i_clk) if (pl_take) pidx <= pidx + 16'h1;
  // Logs of what each end delivered
  always @(posedge i_clk) begin
    if (cmd_v) cmd_n++;
    if (cmd_v) cmd_l = {cmd_t, cmd_o, cmd_ln};
    if (cmd_e) err_n++;
    if (dpl_v) dpl_l = dpl_d;
    if (dpl_v) dpl_n++;
    if (evt_v) evq.push_back({evt_t, evt_o, evt_ln});
    if (hpl_v) hpl_l = hpl_d;
  end
  task automatic hsend(input logic [7:0] t, input logic [7:0] o, input logic [15:0] l);
    h_type = t;
    h_op = o;
    h_len = l;
    pidx = 16'h0;
    send = 1'b1;
    `WT(send_ack)
    send = 1'b0;
  endtask
  task automatic dsend(input logic [7:0] t, input logic [7:0] o, input logic [15:0] l);
    tx_type = t;
    tx_op = o;
    tx_len = l;
    tx_req = 1'b1;
    `WT(tx_ack)
    tx_req = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge i_clk);
    i_nrst = 1'b1;
    `CHK("uart_on", 1'b1, uart_on)
    `CHK("dev_rts_n", 1'b0, link.dev_rts_n)
    hsend(TYPE_REQUEST, 8'h7e, 16'h3);
    `WT(cmd_n == 1)
    `CHK("cmd", {TYPE_REQUEST, 8'h7e, 16'h3}, cmd_l)
    `CHK("cmd_pl", 8'h42, dpl_l)
    `CHK("pl_n", 3, dpl_n)
    $display("test request done");
    for (int i = 0; i < 4; i++) begin
      tx_valid = 1'b1;
      tx_data = {4'h4, 4'(i)};
      @(negedge i_clk);
    end
    tx_valid = 1'b0;
    `CHK("fifo_full", 1'b0, tx_ready)
    dsend(TYPE_INDICATION, 8'h11, 16'h4);
    `WT(evq.size() == 1)
    `CHK("ind", {TYPE_INDICATION, 8'h11, 16'h4}, evq[0])
    `CHK("ind_pl", 8'h43, hpl_l)
    `CHK("fifo_empty", 1'b1, tx_ready)
    hsend(TYPE_REPLY, 8'h11, 16'h0);
    `WT(cmd_n == 2)
    `CHK("reply", {TYPE_REPLY, 8'h11, 16'h0}, cmd_l)
    $display("test indication done");
    hsend(TYPE_REQUEST, 8'h21, 16'h14e);
    `WT(err_n == 1)
    hsend(TYPE_REQUEST, 8'h22, 16'h0);
    `WT(cmd_n == 3)
    `CHK("resync", {TYPE_REQUEST, 8'h22, 16'h0}, cmd_l)
    $display("test oversize done");
    radio = RADIO_SCAN;
    hsend(TYPE_REQUEST, DEF_OP_DISABLE_TL, 16'h0);
    `WT(link.dev_rts_n)
    @(negedge i_clk);
    `CHK("dis_cfm", {TYPE_CONFIRM, DEF_OP_DISABLE_TL, 16'h0}, evq[1])
    `CHK("dis_cmd_n", 3, cmd_n)
    `CHK("uart_off", 1'b0, uart_on)
    `CHK("pm_off", 3'h2, pmode)
    `CHK("slow", 1'b1, slow)
    hsend(TYPE_REQUEST, 8'h33, 16'h1);
    `WT(cmd_n == 4)
    `CHK("h_wake", {TYPE_CONFIRM, DEF_OP_TL_ENABLED, 16'h0}, evq[2])
    `CHK("h_cmd", {TYPE_REQUEST, 8'h33, 16'h1}, cmd_l)
    `CHK("pm_on", 3'h3, pmode)
    $display("test host wake done");
    hsend(TYPE_REQUEST, DEF_OP_DISABLE_TL, 16'h0);
    `WT(link.dev_rts_n)
    dsend(TYPE_INDICATION, 8'h44, 16'h0);
    `WT(evq.size() == 6)
    `CHK("d_wake", {TYPE_CONFIRM, DEF_OP_TL_ENABLED, 16'h0}, evq[4])
    `CHK("d_ind", {TYPE_INDICATION, 8'h44, 16'h0}, evq[5])
    $display("test device wake done");
    hsend(TYPE_REQUEST, DEF_OP_TRANSPARENT, 16'h0);
    `WT(evq.size() == 7)
    `CHK("tr_cfm", {TYPE_CONFIRM, DEF_OP_TRANSPARENT, 16'h0}, evq[6])
    `CHK("tr_on", 1'b1, trans)
    dpl_b = dpl_n;
    hsend(TYPE_REQUEST, 8'h55, 16'h1);
    `WT(dpl_n == dpl_b + 8)
    `CHK("raw_last", END_DELIM, dpl_l)
    `CHK("raw_no_cmd", 4, cmd_n)
    $display("test transparent done");
    summarize();
  end
endmodule
